// ---- fsm_pkg.sv ----
package fsm_pkg;
	// ==========================================
	// clock and timing
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned TAKEOFF_MS      = 500;
	localparam int unsigned LANDING_MS      = 2000;
	localparam int unsigned TAKEOFF_CYCLES  = (TAKEOFF_MS * (CLK_HZ / 1000));
	localparam int unsigned LANDING_CYCLES  = (LANDING_MS * (CLK_HZ / 1000));
	localparam int unsigned TICK_MS_CYCLES  = CLK_HZ / 1000;
	localparam int unsigned FLASH_HALF_MS   = 250;
	// ==========================================
	// speed thresholds in internal unit of 0.01 km/h
	localparam logic [15:0] SPEED_TAKEOFF   = 16'h03E8;
	localparam logic [15:0] SPEED_LANDING   = 16'h01F4;
	// ==========================================
	// widths
	localparam int unsigned SPW   = 16;
	localparam int unsigned ALW   = 20;
	localparam int unsigned CRW   = 24;
	localparam int unsigned VW    = 12;
	localparam int unsigned PW    = 24;
	localparam int unsigned GW    = 7;
	// gauge full scale 100 percent
	localparam logic [GW-1:0] GAUGE_FULL = 7'h64;
	// ==========================================
	// enumerations
	typedef enum logic [1:0] {FSM_LANDED, FSM_AIRBORNE, FSM_SPARE} fsm_flight_t;
	typedef enum logic [2:0] {
		FSM_NAV_SEARCH, FSM_NAV_BARS, FSM_NAV_FAIL, FSM_NAV_LOCK,
		FSM_NAV_FAIL_FLASH, FSM_NAV_LOST
	} fsm_nav_t;
	typedef enum logic [1:0] {FSM_REC_OFF, FSM_REC_READY, FSM_REC_ACTIVE, FSM_REC_ERROR} fsm_rec_t;
	typedef enum logic [1:0] {FSM_AUX_NONE, FSM_AUX_VIDEO, FSM_AUX_RSSI, FSM_AUX_RES} fsm_aux_t;
endpackage : fsm_pkg

// ---- fsm_hold_timer.sv ----
`timescale 1ns/10ps
// ==========================================
// counts cycles while a condition holds; done once the count is reached
module fsm_hold_timer #(
	parameter int unsigned COUNT = 4
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// condition
	input  wire logic cond,
	output logic      done
);
	localparam int unsigned CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
	logic [CW-1:0] cnt;

	// any drop of the condition restarts the wait
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt  <= '0;
			done <= 1'b0;
		end else if (!cond) begin
			cnt  <= '0;
			done <= 1'b0;
		end else if (cnt != LAST) begin
			cnt  <= cnt + CW'(1);
		end else begin
			done <= 1'b1;
		end
	end
endmodule : fsm_hold_timer

// ---- fsm_monitor.sv ----
`timescale 1ns/10ps
module fsm_monitor #(
	parameter int unsigned TAKEOFF_HOLD = fsm_pkg::TAKEOFF_CYCLES,
	parameter int unsigned LANDING_HOLD = fsm_pkg::LANDING_CYCLES,
	parameter int unsigned MS_TICK      = fsm_pkg::TICK_MS_CYCLES
) (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       reset,
	// receiver data, speed in 0.01 km/h
	input  wire logic [fsm_pkg::SPW-1:0]    speed,
	input  wire logic signed [fsm_pkg::ALW-1:0] altitude,
	input  wire logic signed [fsm_pkg::PW-1:0]  lat,
	input  wire logic signed [fsm_pkg::PW-1:0]  lon,
	input  wire logic [8:0]                 heading,
	input  wire logic                       sample_valid,
	input  wire logic                       link_up,
	input  wire logic                       sats_heard,
	input  wire logic                       fix_ok,
	input  wire logic [7:0]                 hdop,
	input  wire logic [3:0]                 sats_used,
	// power and auxiliary sensing
	input  wire logic [fsm_pkg::VW-1:0]     batt_volt,
	input  wire logic [fsm_pkg::VW-1:0]     batt_curr_ma,
	input  wire logic [fsm_pkg::VW-1:0]     aux_volt,
	// configuration
	input  wire logic [fsm_pkg::VW-1:0]     gauge_vmin,
	input  wire logic [fsm_pkg::VW-1:0]     gauge_vmax,
	input  wire fsm_pkg::fsm_aux_t          aux_mode,
	input  wire logic [fsm_pkg::VW-1:0]     aux_low,
	input  wire logic                       rec_enable,
	input  wire logic                       dist_los,
	// card and remote
	input  wire logic                       card_present,
	input  wire logic                       card_fault,
	input  wire logic                       max_alt_clear,
	// state outputs
	output fsm_pkg::fsm_flight_t            flight,
	output fsm_pkg::fsm_rec_t               rec_status,
	output logic                            rec_sample,
	output fsm_pkg::fsm_nav_t               nav_status,
	output logic [7:0]                      nav_value,
	output logic                            flash,
	// position outputs
	output logic signed [fsm_pkg::PW-1:0]   shown_lat,
	output logic signed [fsm_pkg::PW-1:0]   shown_lon,
	output logic signed [fsm_pkg::PW:0]     home_dlat,
	output logic signed [fsm_pkg::PW:0]     home_dlon,
	output logic [8:0]                      home_heading,
	output logic [fsm_pkg::PW+1:0]          home_dist,
	// altitude outputs
	output logic signed [fsm_pkg::ALW:0]    rel_alt,
	output logic signed [fsm_pkg::ALW:0]    max_alt,
	output logic signed [fsm_pkg::ALW:0]    climb,
	// power outputs
	output logic [fsm_pkg::CRW-1:0]         charge_mah,
	output logic [fsm_pkg::GW-1:0]          gauge,
	// auxiliary outputs
	output logic                            aux_show,
	output logic [fsm_pkg::VW-1:0]          aux_value,
	output logic                            aux_flash
);
	import fsm_pkg::*;

	// ==========================================
	// flight state
	logic fast_held;
	logic slow_held;

	fsm_hold_timer #(.COUNT(TAKEOFF_HOLD)) u_takeoff (
		.ref_clk (ref_clk),
		.reset   (reset),
		.cond    (speed > SPEED_TAKEOFF),
		.done    (fast_held)
	);
	// one cycle more than the hold so that it is strictly longer
	fsm_hold_timer #(.COUNT(LANDING_HOLD + 1)) u_landing (
		.ref_clk (ref_clk),
		.reset   (reset),
		.cond    (speed < SPEED_LANDING),
		.done    (slow_held)
	);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flight <= FSM_LANDED;
		end else begin
			unique case (flight)
				FSM_LANDED:   if (fast_held) flight <= FSM_AIRBORNE;
				FSM_AIRBORNE: if (slow_held) flight <= FSM_LANDED;
				default:      flight <= FSM_LANDED;
			endcase
		end
	end

	// ==========================================
	// flight recorder
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rec_status <= FSM_REC_OFF;
			rec_sample <= 1'b0;
		end else begin
			rec_sample <= 1'b0;
			if (!rec_enable) begin
				rec_status <= FSM_REC_OFF;
			end else if (!card_present || card_fault) begin
				rec_status <= FSM_REC_ERROR;
			end else if (flight == FSM_AIRBORNE) begin
				rec_status <= FSM_REC_ACTIVE;
				rec_sample <= sample_valid;
			end else begin
				rec_status <= FSM_REC_READY;
			end
		end
	end

	// ==========================================
	// navigation status
	fsm_nav_t next_nav;
	logic     ever_locked;

	always_comb begin
		next_nav = nav_status;
		unique case (nav_status)
			FSM_NAV_SEARCH: begin
				if (!link_up && ever_locked) next_nav = FSM_NAV_FAIL_FLASH;
				else if (!link_up)           next_nav = FSM_NAV_FAIL;
				else if (fix_ok)             next_nav = FSM_NAV_LOCK;
				else if (sats_heard && !ever_locked) next_nav = FSM_NAV_BARS;
			end
			FSM_NAV_BARS: begin
				if (!link_up)     next_nav = FSM_NAV_FAIL;
				else if (fix_ok)  next_nav = FSM_NAV_LOCK;
			end
			FSM_NAV_FAIL: begin
				if (link_up)      next_nav = FSM_NAV_SEARCH;
			end
			FSM_NAV_LOCK: begin
				if (!link_up)     next_nav = FSM_NAV_FAIL_FLASH;
				else if (!fix_ok) next_nav = FSM_NAV_LOST;
			end
			FSM_NAV_FAIL_FLASH: begin
				if (link_up)      next_nav = FSM_NAV_SEARCH;
			end
			FSM_NAV_LOST: begin
				if (!link_up)     next_nav = FSM_NAV_FAIL_FLASH;
				else if (fix_ok)  next_nav = FSM_NAV_LOCK;
			end
			default: next_nav = FSM_NAV_SEARCH;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			nav_status  <= FSM_NAV_SEARCH;
			ever_locked <= 1'b0;
			nav_value   <= 8'h00;
		end else begin
			nav_status <= next_nav;
			if (next_nav == FSM_NAV_LOCK) ever_locked <= 1'b1;
			// bars and every other state show the used satellite count, lock shows precision (hdop) only
			if (next_nav == FSM_NAV_LOCK) nav_value <= hdop;
			else                          nav_value <= {4'h0, sats_used};
		end
	end

	// ==========================================
	// coordinates frozen whenever not locked
	logic pos_live;
	assign pos_live = (next_nav == FSM_NAV_LOCK) && sample_valid;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			shown_lat <= '0;
			shown_lon <= '0;
		end else if (pos_live) begin
			shown_lat <= lat;
			shown_lon <= lon;
		end
	end

	// ==========================================
	// flash divider, also the millisecond tick
	localparam int unsigned MSW = $clog2(MS_TICK + 1);
	logic [MSW-1:0] ms_cnt;
	logic           ms_tick;
	logic [8:0]     flash_cnt;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ms_cnt    <= '0;
			ms_tick   <= 1'b0;
			flash_cnt <= 9'h000;
			flash     <= 1'b0;
		end else begin
			ms_tick <= 1'b0;
			if (ms_cnt == MSW'(MS_TICK - 1)) begin
				ms_cnt  <= '0;
				ms_tick <= 1'b1;
			end else begin
				ms_cnt <= ms_cnt + MSW'(1);
			end
			if (ms_tick) begin
				if (flash_cnt == 9'(FLASH_HALF_MS - 1)) begin
					flash_cnt <= 9'h000;
					flash     <= ~flash;
				end else begin
					flash_cnt <= flash_cnt + 9'h001;
				end
			end
		end
	end

	// ==========================================
	// home reference taken while landed
	logic signed [PW-1:0]  home_lat;
	logic signed [PW-1:0]  home_lon;
	logic signed [ALW-1:0] home_alt;
	logic signed [PW:0]    dlat;
	logic signed [PW:0]    dlon;
	logic [PW:0]           adlat;
	logic [PW:0]           adlon;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			home_lat <= '0;
			home_lon <= '0;
			home_alt <= '0;
		end else if (flight == FSM_LANDED && sample_valid && fix_ok) begin
			home_lat <= lat;
			home_lon <= lon;
			home_alt <= altitude;
		end
	end

	assign dlat  = (PW+1)'(home_lat) - (PW+1)'(shown_lat);
	assign dlon  = (PW+1)'(home_lon) - (PW+1)'(shown_lon);
	assign adlat = dlat[PW] ? (PW+1)'(-dlat) : dlat;
	assign adlon = dlon[PW] ? (PW+1)'(-dlon) : dlon;

	// distance is an octagonal approximation: max plus half of min
	logic [PW+1:0] ground_d;
	logic [PW+1:0] abs_alt;
	logic [PW+1:0] gmax;
	logic [PW+1:0] gmin;
	logic [PW+1:0] los_d;
	always_comb begin
		gmax     = (adlat > adlon) ? (PW+2)'(adlat) : (PW+2)'(adlon);
		gmin     = (adlat > adlon) ? (PW+2)'(adlon) : (PW+2)'(adlat);
		ground_d = gmax + (gmin >> 1);
		abs_alt  = rel_alt[ALW] ? (PW+2)'(-rel_alt) : (PW+2)'(rel_alt);
		los_d    = (ground_d > abs_alt) ? ground_d + (abs_alt >> 1) : abs_alt + (ground_d >> 1);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			home_dlat    <= '0;
			home_dlon    <= '0;
			home_heading <= 9'h000;
			home_dist    <= '0;
		end else begin
			home_dlat    <= dlat;
			home_dlon    <= dlon;
			home_heading <= heading;
			home_dist    <= dist_los ? los_d : ground_d;
		end
	end

	// ==========================================
	// altitude
	logic signed [ALW:0] next_rel;
	logic signed [ALW:0] prev_rel;
	assign next_rel = (ALW+1)'(altitude) - (ALW+1)'(home_alt);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rel_alt  <= '0;
			prev_rel <= '0;
			climb    <= '0;
			max_alt  <= '0;
		end else begin
			if (sample_valid) begin
				rel_alt  <= next_rel;
				prev_rel <= rel_alt;
			end
			climb <= rel_alt - prev_rel;
			if (max_alt_clear)          max_alt <= '0;
			else if (rel_alt > max_alt) max_alt <= rel_alt;
		end
	end

	// ==========================================
	// charge: mA per millisecond summed, reset clears it only
	logic [CRW+11:0] charge_uas;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			charge_uas <= '0;
			charge_mah <= '0;
		end else begin
			if (ms_tick) charge_uas <= charge_uas + (CRW+12)'(batt_curr_ma);
			// 3.6e6 mA-ms per mAh; divide is slow but only feeds a display
			charge_mah <= CRW'(charge_uas / (CRW+12)'(3_600_000));
		end
	end

	// ==========================================
	// fuel gauge
	logic [VW-1:0]    span;
	logic [VW-1:0]    above;
	logic [VW+GW-1:0] scaled;
	always_comb begin
		span   = (gauge_vmax > gauge_vmin) ? gauge_vmax - gauge_vmin : VW'(1);
		above  = (batt_volt > gauge_vmin) ? batt_volt - gauge_vmin : '0;
		scaled = (VW+GW)'(above) * (VW+GW)'(GAUGE_FULL);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) gauge <= '0;
		else if (batt_volt >= gauge_vmax) gauge <= GAUGE_FULL;
		else gauge <= GW'(scaled / (VW+GW)'(span));
	end

	// ==========================================
	// auxiliary port
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			aux_show  <= 1'b0;
			aux_value <= '0;
			aux_flash <= 1'b0;
		end else begin
			unique case (aux_mode)
				FSM_AUX_VIDEO: begin
					aux_show  <= 1'b1;
					aux_value <= aux_volt;
					aux_flash <= (aux_volt < aux_low) && flash;
				end
				FSM_AUX_RSSI: begin
					aux_show  <= 1'b1;
					aux_value <= aux_volt;
					aux_flash <= (aux_volt < aux_low) && flash;
				end
				default: begin
					aux_show  <= 1'b0;
					aux_value <= '0;
					aux_flash <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// checks
	sequence s_slow_long;
		(speed < SPEED_LANDING) [*8];
	endsequence

	a_takeoff_needs_speed: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(flight == FSM_AIRBORNE) |-> $past(speed) > SPEED_TAKEOFF)
		else $error("takeoff without speed");
	a_landing_needs_slow: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(flight == FSM_AIRBORNE) |-> $past(speed, 2) < SPEED_LANDING)
		else $error("landing without slow speed");
	a_no_early_land: assert property (@(posedge ref_clk) disable iff (reset)
		(flight == FSM_AIRBORNE && speed >= SPEED_LANDING) |=> flight == FSM_AIRBORNE)
		else $error("left airborne too early");
	a_rec_active_air: assert property (@(posedge ref_clk) disable iff (reset)
		(rec_enable && card_present && !card_fault && flight == FSM_AIRBORNE) |=> rec_status == FSM_REC_ACTIVE)
		else $error("not recording while airborne");
	a_rec_error_card: assert property (@(posedge ref_clk) disable iff (reset)
		(rec_enable && !card_present) |=> rec_status == FSM_REC_ERROR)
		else $error("missing card not flagged");
	a_rec_off_disabled: assert property (@(posedge ref_clk) disable iff (reset)
		!rec_enable |=> rec_status == FSM_REC_OFF && !rec_sample)
		else $error("status shown while disabled");
	a_freeze_unlocked: assert property (@(posedge ref_clk) disable iff (reset)
		(nav_status != FSM_NAV_LOCK && next_nav != FSM_NAV_LOCK) |=> $stable(shown_lat))
		else $error("coordinates moved without lock");
	a_fail_after_lock: assert property (@(posedge ref_clk) disable iff (reset)
		(nav_status == FSM_NAV_LOCK && !link_up) |=> nav_status == FSM_NAV_FAIL_FLASH)
		else $error("link loss after lock not flagged");
	a_max_clear: assert property (@(posedge ref_clk) disable iff (reset)
		max_alt_clear |=> max_alt == '0)
		else $error("max altitude not cleared");
	a_aux_none_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		(aux_mode == FSM_AUX_NONE) [*2] |-> !aux_show && !aux_flash)
		else $error("aux shown while not connected");
	a_slow_keeps_landed: assert property (@(posedge ref_clk) disable iff (reset)
		(flight == FSM_LANDED) ##0 s_slow_long |-> flight == FSM_LANDED)
		else $error("airborne at low speed");
endmodule : fsm_monitor

// ---- fsm_rx_model.sv ----
`timescale 1ns/10ps
// ==========================================
// navigation receiver model: a sample every 8 cycles while the link is up
module fsm_rx_model (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               reset,
	// scenario control
	input  wire logic               link,
	input  wire logic               sats,
	input  wire logic               fix,
	input  wire logic signed [19:0] alt_in,
	input  wire logic signed [23:0] lat_in,
	// receiver side
	output logic                    sample_valid = 1'b0,
	output logic signed [19:0]      altitude     = 20'sh00000,
	output logic signed [23:0]      lat          = 24'sh000000,
	output logic signed [23:0]      lon          = 24'sh000000,
	output logic [8:0]              heading      = 9'h000,
	output logic                    link_up      = 1'b0,
	output logic                    sats_heard   = 1'b0,
	output logic                    fix_ok       = 1'b0,
	output logic [7:0]              hdop         = 8'h00,
	output logic [3:0]              sats_used    = 4'h0
);
	logic [2:0] phase = 3'h0;
	// ==========================================
	// a dead link sends nothing: data lines toggle so stale values cannot pass
	always @(negedge ref_clk) begin
		phase <= reset ? 3'h0 : phase + 3'h1;
		link_up <= link;
		sats_heard <= link & sats;
		fix_ok <= link & fix;
		sample_valid <= link && (phase == 3'h7);
		altitude <= link ? alt_in : ~altitude;
		lat <= link ? lat_in : ~lat;
		lon <= link ? 24'sh000000 : ~lon;
		heading <= link ? 9'h000 : ~heading;
		hdop <= link ? 8'h12 : ~hdop;
		sats_used <= link ? 4'h7 : ~sats_used;
	end
endmodule : fsm_rx_model

// ---- fsm_monitor_tb.sv ----
`timescale 1ns/10ps
module fsm_monitor_tb;
	import fsm_pkg::*;
	// ==========================================
	// stimulus and observed signals
	logic ref_clk = 1'b0, reset = 1'b1, r_link = 1'b0, r_sats = 1'b0, r_fix = 1'b0;
	logic rec_enable = 1'b1, dist_los = 1'b0, card_present = 1'b1, card_fault = 1'b0, max_alt_clear = 1'b0;
	logic [15:0] speed = 16'h0000;
	logic signed [19:0] r_alt = 20'sh00064;
	logic signed [23:0] r_lat = 24'sh000000;
	logic [11:0] batt_volt = 12'h44C, batt_curr_ma = 12'hFA0, aux_volt = 12'h384;
	logic [11:0] gauge_vmin = 12'h3E8, gauge_vmax = 12'h4B0, aux_low = 12'h320;
	fsm_aux_t aux_mode = FSM_AUX_NONE;
	logic sample_valid, link_up, sats_heard, fix_ok, rec_sample, flash, aux_show, aux_flash;
	logic signed [19:0] altitude;
	logic signed [23:0] lat, lon, shown_lat, shown_lon, keep;
	logic [8:0] heading, home_heading;
	logic [7:0] hdop, nav_value;
	logic [3:0] sats_used;
	logic [11:0] aux_value;
	fsm_flight_t flight;
	fsm_rec_t rec_status;
	fsm_nav_t nav_status;
	logic signed [24:0] home_dlat, home_dlon;
	logic [25:0] home_dist, gd;
	logic signed [20:0] rel_alt, max_alt, climb;
	logic [23:0] charge_mah, c0;
	logic [6:0] gauge;
	int fails = 0, total_checks = 0, pulses;
	// ==========================================
	// table rows, taken while landed
	typedef struct {logic en, pres, flt; fsm_aux_t md; logic [11:0] av, bv; fsm_rec_t rec; logic show; logic [6:0] g;} fsm_row_t;
	fsm_row_t rows [5] = '{
		'{1'b1, 1'b1, 1'b0, FSM_AUX_VIDEO, 12'h384, 12'h3E8, FSM_REC_READY, 1'b1, 7'h00},
		'{1'b1, 1'b0, 1'b0, FSM_AUX_RSSI, 12'h2BC, 12'h4B0, FSM_REC_ERROR, 1'b1, 7'h64},
		'{1'b1, 1'b1, 1'b1, FSM_AUX_NONE, 12'h384, 12'h44C, FSM_REC_ERROR, 1'b0, 7'h32},
		'{1'b0, 1'b1, 1'b1, FSM_AUX_VIDEO, 12'h384, 12'h4B0, FSM_REC_OFF, 1'b1, 7'h64},
		'{1'b0, 1'b1, 1'b0, FSM_AUX_NONE, 12'h384, 12'h3E8, FSM_REC_OFF, 1'b0, 7'h00}};
	// ==========================================
	// design and receiver model
	fsm_monitor #(.TAKEOFF_HOLD(20), .LANDING_HOLD(40), .MS_TICK(10)) u_dut (.ref_clk(ref_clk), .reset(reset),
		.speed(speed), .altitude(altitude), .lat(lat), .lon(lon), .heading(heading), .sample_valid(sample_valid),
		.link_up(link_up), .sats_heard(sats_heard), .fix_ok(fix_ok), .hdop(hdop), .sats_used(sats_used),
		.batt_volt(batt_volt), .batt_curr_ma(batt_curr_ma), .aux_volt(aux_volt), .gauge_vmin(gauge_vmin),
		.gauge_vmax(gauge_vmax), .aux_mode(aux_mode), .aux_low(aux_low), .rec_enable(rec_enable),
		.dist_los(dist_los), .card_present(card_present), .card_fault(card_fault), .max_alt_clear(max_alt_clear),
		.flight(flight), .rec_status(rec_status), .rec_sample(rec_sample), .nav_status(nav_status),
		.nav_value(nav_value), .flash(flash), .shown_lat(shown_lat), .shown_lon(shown_lon), .home_dlat(home_dlat),
		.home_dlon(home_dlon), .home_heading(home_heading), .home_dist(home_dist), .rel_alt(rel_alt),
		.max_alt(max_alt), .climb(climb), .charge_mah(charge_mah), .gauge(gauge), .aux_show(aux_show),
		.aux_value(aux_value), .aux_flash(aux_flash));
	fsm_rx_model u_rx (.ref_clk(ref_clk), .reset(reset), .link(r_link), .sats(r_sats), .fix(r_fix),
		.alt_in(r_alt), .lat_in(r_lat), .sample_valid(sample_valid), .altitude(altitude), .lat(lat), .lon(lon),
		.heading(heading), .link_up(link_up), .sats_heard(sats_heard), .fix_ok(fix_ok), .hdop(hdop),
		.sats_used(sats_used));
	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t value %0h, expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_true(input logic c);
		total_checks++;
		if (c !== 1'b1) begin
			fails++;
			$display("[ERR] %0t condition not met", $time);
		end
	endtask : chk_true
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic wait_flight(input fsm_flight_t f);
		for (int i = 0; i < 10 && flight !== f; i++) @(negedge ref_clk);
	endtask : wait_flight
	task conclude;
		if (fails == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		fails++;
		conclude();
	end
	// ==========================================
	// main sequence
	initial begin
		cyc(5);
		chk(flight, FSM_LANDED);
		chk(rec_status, FSM_REC_OFF);
		chk(nav_status, FSM_NAV_SEARCH);
		chk(charge_mah, 0);
		reset = 1'b0;
		foreach (rows[i]) begin
			{rec_enable, card_present, card_fault} = {rows[i].en, rows[i].pres, rows[i].flt};
			aux_mode = rows[i].md;
			{aux_volt, batt_volt} = {rows[i].av, rows[i].bv};
			cyc(4);
			chk(rec_status, rows[i].rec);
			chk(aux_show, rows[i].show);
			if (rows[i].show) chk(aux_value, rows[i].av);
			chk(gauge, rows[i].g);
		end
		{rec_enable, card_present, card_fault} = 3'b110;
		{r_link, r_sats} = 2'b11;
		cyc(4);
		chk(nav_status, FSM_NAV_BARS);
		chk(nav_value, 8'h07);
		r_link = 1'b0;
		cyc(4);
		chk(nav_status, FSM_NAV_FAIL);
		{r_link, r_sats} = 2'b10;
		cyc(4);
		chk(nav_status, FSM_NAV_SEARCH);
		{r_sats, r_fix} = 2'b11;
		cyc(20);
		chk(nav_status, FSM_NAV_LOCK);
		chk(nav_value, 8'h12);
		c0 = charge_mah;
		speed = 16'h03E8;
		cyc(60);
		chk(flight, FSM_LANDED);
		speed = 16'h03E9;
		cyc(19);
		speed = 16'h0000;
		cyc(5);
		chk(flight, FSM_LANDED);
		speed = 16'h03E9;
		cyc(18);
		chk(flight, FSM_LANDED);
		wait_flight(FSM_AIRBORNE);
		chk(flight, FSM_AIRBORNE);
		cyc(2);
		chk(rec_status, FSM_REC_ACTIVE);
		pulses = 0;
		for (int i = 0; i < 50; i++) begin
			r_alt = r_alt + 20'sh00005;
			cyc(1);
			pulses += int'(rec_sample === 1'b1);
		end
		chk_true(pulses > 0);
		chk_true(climb > 0);
		// hold the peak long enough for a receiver sample to catch it
		cyc(20);
		for (int i = 0; i < 50; i++) begin
			r_alt = r_alt - 20'sh00002;
			cyc(1);
		end
		chk_true(climb < 0);
		r_lat = 24'sh0003E8;
		cyc(20);
		chk(rel_alt, 32'h96);
		chk(max_alt, 32'hFA);
		chk(home_dlat, 32'hFFFFFC18);
		gd = home_dist;
		chk(gd, 32'h3E8);
		dist_los = 1'b1;
		cyc(4);
		chk_true(home_dist > gd);
		max_alt_clear = 1'b1;
		cyc(1);
		max_alt_clear = 1'b0;
		cyc(5);
		chk(max_alt, 32'h96);
		speed = 16'h01F4;
		cyc(60);
		chk(flight, FSM_AIRBORNE);
		speed = 16'h0000;
		cyc(38);
		chk(flight, FSM_AIRBORNE);
		wait_flight(FSM_LANDED);
		chk(flight, FSM_LANDED);
		cyc(2);
		chk(rec_status, FSM_REC_READY);
		r_fix = 1'b0;
		keep = shown_lat;
		r_lat = 24'sh000100;
		cyc(20);
		chk(nav_status, FSM_NAV_LOST);
		chk(shown_lat, keep);
		r_fix = 1'b1;
		cyc(20);
		chk(shown_lat, 32'h100);
		r_link = 1'b0;
		cyc(20);
		chk(nav_status, FSM_NAV_FAIL_FLASH);
		chk(shown_lat, 32'h100);
		{r_link, r_fix} = 2'b10;
		cyc(4);
		chk(nav_status, FSM_NAV_SEARCH);
		aux_mode = FSM_AUX_VIDEO;
		aux_volt = 12'h2BC;
		for (int i = 0; i < 5100 && aux_flash !== 1'b1; i++) cyc(1);
		chk(aux_flash, 1'b1);
		aux_mode = FSM_AUX_RSSI;
		for (int i = 0; i < 5100 && aux_flash !== 1'b1; i++) cyc(1);
		chk(aux_flash, 1'b1);
		aux_volt = 12'h384;
		cyc(3);
		chk(aux_flash, 1'b0);
		chk_true(charge_mah >= c0);
		conclude();
	end
endmodule : fsm_monitor_tb
